// ### dsp_host_cfg.svh
// Constants for the display serial host controller
`ifndef DSP_HOST_CFG_SVH
`define DSP_HOST_CFG_SVH
// Register offsets
`define REG_CTRL      12'h000
`define REG_TXDATA    12'h004
`define REG_STATUS    12'h008
`define REG_RXDATA    12'h00C
`define REG_DIV       12'h010
// Control fields
`define CTRL_START    0
`define CTRL_FLAG     1
`define CTRL_HOLD     2
`define CTRL_READ     3
`define CTRL_DUAL     4
`define CTRL_SWAP     5
`define CTRL_QUAD     6
`define CTRL_MODE_LO  8
`define CTRL_MODE_HI  9
`define CTRL_LEN_LO   12
`define CTRL_LEN_HI   13
`define CTRL_RDEN     16
// Mode encodings of the link
`define MODE_3LINE    2'h0
`define MODE_4LINE    2'h1
`define MODE_QUAD     2'h2
// Interface select patterns
`define SEL_3LINE     4'b1100
`define SEL_4LINE     4'b1101
`define SEL_DUAL3     4'b0110
`define SEL_DUAL4     4'b1011
`define SEL_QUAD      4'b0101
// Quad first-byte codes
`define QUAD_SINGLE   8'h02
`define QUAD_ADDR1    8'h32
`define QUAD_ALL4     8'h12
// Reset values and timing
`define DIV_RESET     8'h08
`define CS_GAP_NS     200
`define CS_GAP_CYC    ((`CS_GAP_NS + 9) / 10)
`endif

// ### dsp_host_pkg.sv
// Types for the display serial host controller
package dsp_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_LOW   = 3'b010,
        ST_HIGH  = 3'b011,
        ST_GAP   = 3'b100
    } link_state_t;
    typedef enum logic [1:0] {
        LANE_ONE  = 2'b00,
        LANE_TWO  = 2'b01,
        LANE_FOUR = 2'b10
    } lane_use_t;
endpackage : dsp_host_pkg

// ### pin_sync.sv
// Two-flop synchroniser for pin inputs
module pin_sync
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Pins in and synchronised copies out
    input  wire logic [1:0] pin_in,
    output logic      [1:0] pin_sync_out
);
    logic [1:0] stage1;
    // First stage read only by second stage
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stage1       <= 2'h0;
            pin_sync_out <= 2'h0;
        end else begin
            stage1       <= pin_in;
            pin_sync_out <= stage1;
        end
    end
endmodule : pin_sync

// ### clk_divider.sv
// Serial clock phase generator
module clk_divider
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Control
    input  wire logic       run,
    input  wire logic [7:0] half_period,
    // One-cycle phase pulse
    output logic            tick
);
    logic [7:0] count;
    // Count up each half period while a frame is running
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else if (!run) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else if (count >= half_period) begin
            count <= 8'h00;
            tick  <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick  <= 1'b0;
        end
    end
endmodule : clk_divider

// ### dsp_host.sv
// Display serial link host: APB register slave driving the serial pins
`include "dsp_host_cfg.svh"
module dsp_host
    import dsp_host_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link pins
    output logic             chip_select_n,
    output logic             serial_clk,
    output logic             command_flag_pin,
    output logic             serial_in_line,
    output logic             serial_in_line_oe,
    output logic             quad_lane1_out,
    output logic             quad_lane2_pin,
    output logic             quad_lane3_pin,
    output logic             quad_oe,
    input  wire logic        serial_in_line_in,
    input  wire logic        serial_out_line,
    // Strap and select pins driven to the device
    output logic [3:0]       interface_select_pins,
    output logic             port_reset_n
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers and signals
    logic [31:0] ctrl;
    logic [31:0] txdata;
    logic [31:0] rxdata;
    logic [7:0]  div;
    logic        busy;
    logic        done;
    link_state_t state;
    link_state_t next_state;
    logic [5:0]  bits_left;
    logic [32:0] shreg;
    logic        reading;
    logic        replying;
    logic        tick;
    logic [1:0]  rx_sync;
    logic [7:0]  gap_cnt;
    lane_use_t   lanes;
    logic [1:0]  mode;
    logic        access;
    logic        wr_start;

    assign access   = psel && penable;
    assign wr_start = access && pwrite && (paddr == `REG_CTRL) && pwdata[`CTRL_START] && !busy;
    assign mode     = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];

    // Number of shifted bits of one frame
    function automatic logic [5:0] frame_bits(input logic [1:0] md, input logic dual,
                                              input logic quad, input logic rd,
                                              input logic [1:0] len);
        logic [5:0] n;
        n = 6'd8;
        if (rd) begin
            case (len)
                2'h0:    n = 6'd8;
                2'h1:    n = 6'd24;
                default: n = 6'd32;
            endcase
        end else if (dual) begin
            // Flag clock plus twelve two-bit clocks of one 24-bit pixel
            n = 6'd13;
        end else if (quad) begin
            // Whole word, four bits per clock
            n = 6'd8;
        end
        // Besides the dual pixel, only a written 3-line byte carries the flag clock
        if (md == `MODE_3LINE && !dual && !quad && !rd) begin
            n = n + 6'd1;
        end
        return n;
    endfunction : frame_bits

    // Lane usage for a frame
    function automatic lane_use_t lane_of(input logic dual, input logic quad, input logic rd);
        lane_use_t l;
        if (rd) begin
            l = LANE_ONE;
        end else if (quad) begin
            l = LANE_FOUR;
        end else if (dual) begin
            l = LANE_TWO;
        end else begin
            l = LANE_ONE;
        end
        return l;
    endfunction : lane_of

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for returned data
    pin_sync u_sync (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .pin_in       ({serial_out_line, serial_in_line_in}),
        .pin_sync_out (rx_sync)
    );

    // Half-period generator for the serial clock
    clk_divider u_div (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .run         (state == ST_LOW || state == ST_HIGH),
        .half_period (div),
        .tick        (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl   <= 32'h0000_0000;
            txdata <= 32'h0000_0000;
            div    <= `DIV_RESET;
        end else if (access && pwrite && !busy) begin
            case (paddr)
                `REG_CTRL:   ctrl   <= pwdata;
                `REG_TXDATA: txdata <= pwdata;
                `REG_DIV:    div    <= pwdata[7:0];
                default:     ;
            endcase
        end
    end

    // APB answer: zero wait states, error on unmapped address
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == `REG_CTRL || paddr == `REG_TXDATA ||
                       paddr == `REG_STATUS || paddr == `REG_RXDATA || paddr == `REG_DIV);
            case (paddr)
                `REG_CTRL:   prdata <= ctrl;
                `REG_TXDATA: prdata <= txdata;
                `REG_STATUS: prdata <= {30'h0000_0000, done, busy};
                `REG_RXDATA: prdata <= rxdata;
                `REG_DIV:    prdata <= {24'h00_0000, div};
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  if (wr_start) next_state = ST_SETUP;
            ST_SETUP: next_state = ST_LOW;
            ST_LOW:   if (tick) next_state = ST_HIGH;
            ST_HIGH:  if (tick) next_state = (bits_left == 6'd1 && !reading) ? ST_GAP : ST_LOW;
            ST_GAP:   if (gap_cnt == 8'h00 && chip_select_n) next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Shift control, pin drive and read capture
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            chip_select_n     <= 1'b1;
            serial_clk        <= 1'b0;
            command_flag_pin  <= 1'b0;
            serial_in_line    <= 1'b0;
            serial_in_line_oe <= 1'b0;
            quad_lane1_out    <= 1'b0;
            quad_lane2_pin    <= 1'b0;
            quad_lane3_pin    <= 1'b0;
            quad_oe           <= 1'b0;
            shreg             <= 33'h0_0000_0000;
            bits_left         <= 6'd0;
            reading           <= 1'b0;
            replying          <= 1'b0;
            lanes             <= LANE_ONE;
            rxdata            <= 32'h0000_0000;
            gap_cnt           <= 8'h00;
            busy              <= 1'b0;
            done              <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (wr_start) begin
                        busy    <= 1'b1;
                        done    <= 1'b0;
                        reading <= pwdata[`CTRL_READ] && pwdata[`CTRL_RDEN];
                        lanes   <= lane_of(pwdata[`CTRL_DUAL], pwdata[`CTRL_QUAD],
                                           pwdata[`CTRL_READ]);
                        bits_left <= frame_bits(pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO],
                                                pwdata[`CTRL_DUAL], pwdata[`CTRL_QUAD],
                                                1'b0, 2'h0);
                        // Flag bit ahead of the byte, MSB first
                        shreg <= {pwdata[`CTRL_FLAG] || pwdata[`CTRL_DUAL],
                                  txdata};
                    end
                end
                ST_SETUP: begin
                    chip_select_n    <= 1'b0;
                    serial_clk       <= 1'b0;
                    command_flag_pin <= ctrl[`CTRL_FLAG];
                    serial_in_line_oe <= 1'b1;
                    quad_oe          <= (lanes != LANE_ONE);
                    if (lanes == LANE_FOUR) begin
                        // First nibble on all four lanes, highest bit on lane three
                        serial_in_line <= shreg[28];
                        quad_lane1_out <= shreg[29];
                        quad_lane2_pin <= shreg[30];
                        quad_lane3_pin <= shreg[31];
                        shreg          <= {shreg[28:0], 4'h0};
                    end else if (mode == `MODE_3LINE && lanes != LANE_TWO) begin
                        serial_in_line <= shreg[32];
                        shreg          <= {shreg[31:0], 1'b0};
                    end else if (lanes == LANE_TWO) begin
                        // Flag on primary, first pixel bit waits for the first cycle
                        serial_in_line <= 1'b1;
                    end else begin
                        serial_in_line <= shreg[31];
                        shreg          <= {shreg[31:0], 1'b0};
                    end
                end
                ST_LOW: begin
                    if (tick) begin
                        serial_clk <= 1'b1;
                        if (replying) begin
                            rxdata <= {rxdata[30:0], rx_sync[1]};
                        end
                    end
                end
                ST_HIGH: begin
                    if (tick) begin
                        serial_clk <= 1'b0;
                        if (bits_left == 6'd1 && reading) begin
                            // Command done, now collect the reply
                            bits_left         <= frame_bits(mode, 1'b0, 1'b0, 1'b1,
                                                            ctrl[`CTRL_LEN_HI:`CTRL_LEN_LO]);
                            serial_in_line_oe <= 1'b0;
                            reading           <= 1'b0;
                            replying          <= 1'b1;
                            rxdata            <= 32'h0000_0000;
                        end else begin
                            bits_left <= bits_left - 6'd1;
                        end
                        case (lanes)
                            LANE_TWO: begin
                                // Swap picks which line carries the high bit
                                serial_in_line <= ctrl[`CTRL_SWAP] ? shreg[22] : shreg[23];
                                quad_lane1_out <= ctrl[`CTRL_SWAP] ? shreg[23] : shreg[22];
                                shreg          <= {shreg[30:0], 2'b00};
                            end
                            LANE_FOUR: begin
                                serial_in_line <= shreg[28];
                                quad_lane1_out <= shreg[29];
                                quad_lane2_pin <= shreg[30];
                                quad_lane3_pin <= shreg[31];
                                shreg          <= {shreg[28:0], 4'h0};
                            end
                            default: begin
                                serial_in_line <= (mode == `MODE_3LINE) ? shreg[32] : shreg[31];
                                shreg          <= {shreg[31:0], 1'b0};
                            end
                        endcase
                    end
                end
                ST_GAP: begin
                    chip_select_n     <= 1'b1;
                    replying          <= 1'b0;
                    serial_in_line_oe <= 1'b0;
                    quad_oe           <= 1'b0;
                    if (chip_select_n) begin
                        gap_cnt <= gap_cnt - 8'h01;
                    end else begin
                        gap_cnt <= 8'(`CS_GAP_CYC);
                    end
                    if (gap_cnt == 8'h00 && chip_select_n) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    // Select pins and device reset follow control settings
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            interface_select_pins <= `SEL_3LINE;
            port_reset_n          <= 1'b0;
        end else begin
            port_reset_n <= !ctrl[`CTRL_HOLD];
            if (ctrl[`CTRL_QUAD]) begin
                interface_select_pins <= `SEL_QUAD;
            end else if (mode == `MODE_4LINE) begin
                interface_select_pins <= ctrl[`CTRL_DUAL] ? `SEL_DUAL4 : `SEL_4LINE;
            end else begin
                interface_select_pins <= ctrl[`CTRL_DUAL] ? `SEL_DUAL3 : `SEL_3LINE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_frame_open;
        $fell(chip_select_n);
    endsequence

    a_cs_before_clk: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(serial_clk) |-> !chip_select_n)
        else $error("serial clock rose with chip select high");
    a_clk_idle_low: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_frame_open |-> !serial_clk)
        else $error("clock not low at frame start");
    a_data_on_fall: assert property (@(posedge sys_clk) disable iff (!resetn)
        ($changed(serial_in_line) && !chip_select_n && state != ST_SETUP) |-> !serial_clk)
        else $error("data changed while clock high");
    a_cs_high_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == ST_IDLE) |-> chip_select_n)
        else $error("chip select low while idle");
    a_busy_frame: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_start |=> busy ##1 !chip_select_n)
        else $error("start did not open a frame");
    a_quad_select: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ctrl[`CTRL_QUAD] && busy) |-> ##[0:2] interface_select_pins == `SEL_QUAD)
        else $error("quad select pattern missing");
    a_dual_flag_one: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == ST_SETUP && lanes == LANE_TWO) |=> serial_in_line)
        else $error("dual frame flag not one");
    a_read_lane_one: assert property (@(posedge sys_clk) disable iff (!resetn)
        (busy && ctrl[`CTRL_READ]) |-> !quad_oe)
        else $error("read used extra lanes");
endmodule : dsp_host

// ### dsp_dev_model.sv
// Behavioural model of the display device serial port
module dsp_dev_model
(
    // Host pins
    input  wire logic        chip_select_n,
    input  wire logic        serial_clk,
    input  wire logic        command_flag_pin,
    input  wire logic [3:0]  lanes,
    input  wire logic [3:0]  interface_select_pins,
    input  wire logic [31:0] reply,
    // Device answer and capture record
    output logic             serial_out_line,
    output logic [3:0][63:0] cap,
    output logic             flag_seen,
    output int               n_bits
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] shreg;
    int          cmd_len;
    // Strap level of the identification code's low bit
    localparam logic CODE_LOW_BIT = 1'b0;
    // Command length: 4-line bytes carry no flag bit
    assign cmd_len = (interface_select_pins == 4'b1101) ? 8 : 9;
    // Capture all lanes on rising clock; a new selection drops any earlier partial byte
    always @(posedge serial_clk or negedge chip_select_n) begin
        if (!serial_clk) begin
            n_bits <= 0;
        end else if (!chip_select_n) begin
            for (int i = 0; i < 4; i++) begin
                cap[i] <= {(n_bits == 0) ? 63'h0 : cap[i][62:0], lanes[i]};
            end
            flag_seen <= command_flag_pin;
            n_bits    <= n_bits + 1;
        end
    end
    // Reply shifts out on falling clock after the command; released line shows inverse
    always @(negedge serial_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            serial_out_line <= (serial_out_line === 1'b1) ? 1'b0 : 1'b1;
            shreg           <= {reply[31:1], CODE_LOW_BIT};
        end else if (n_bits >= cmd_len) begin
            serial_out_line <= shreg[31];
            shreg           <= {shreg[30:0], 1'b0};
        end
    end
endmodule : dsp_dev_model

// ### dsp_host_tb.sv
// Self-checking bench for the display serial link host
`include "dsp_host_cfg.svh"
module dsp_host_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic             sys_clk, resetn, psel, penable, pwrite, slv, pready, pslverr;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, q, reply;
    logic             chip_select_n, serial_clk, command_flag_pin, serial_in_line;
    logic             serial_in_line_oe, quad_lane1_out, quad_lane2_pin, quad_lane3_pin;
    logic             quad_oe, serial_out_line, flag_seen, sda, port_reset_n;
    logic [3:0]       interface_select_pins;
    logic [3:0][63:0] cap;
    logic [7:0]       codes [3] = '{8'h02, 8'h32, 8'h12};
    int               n_bits, err_total, checks_done;
    ////////////////////////////////////////////////////////////////////////////////
    // Wire level of the primary line: inverse of last value when released
    assign sda = serial_in_line_oe ? serial_in_line : ~serial_in_line;
    dsp_host u_dut (
        .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .chip_select_n, .serial_clk, .command_flag_pin, .serial_in_line,
        .serial_in_line_oe, .quad_lane1_out, .quad_lane2_pin, .quad_lane3_pin, .quad_oe,
        .serial_in_line_in(sda), .serial_out_line, .interface_select_pins, .port_reset_n
    );
    dsp_dev_model u_dev (
        .chip_select_n, .serial_clk, .command_flag_pin,
        .lanes({quad_lane3_pin, quad_lane2_pin, quad_lane1_out, sda}),
        .interface_select_pins, .reply, .serial_out_line, .cap, .flag_seen, .n_bits
    );
    // System clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic results;
        $display("checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q       = prdata;
        slv     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    // Configure, start one frame and poll until not busy
    task automatic frame(input logic [31:0] ctrl, input logic [31:0] tx);
        apb(1'b1, `REG_TXDATA, tx);
        apb(1'b1, `REG_CTRL, ctrl);
        apb(1'b1, `REG_CTRL, ctrl | 32'h0000_0001);
        q = 32'h0000_0001;
        for (int i = 0; i < 3000 && q[0] !== 1'b0; i++) begin
            apb(1'b0, `REG_STATUS, 32'h0000_0000);
        end
        chk({chip_select_n, q[1:0]}, 3'b110);
    endtask : frame
    // Serial clock only rises while the device is selected
    always @(posedge serial_clk) chk(chip_select_n, 1'b0);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle pins, unmapped access and divider reset value
    task automatic t_reset;
        chk({chip_select_n, serial_clk, port_reset_n}, 3'b101);
        chk(interface_select_pins, 4'b1100);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({slv, q}, {1'b1, 32'h0000_0000});
        apb(1'b0, `REG_DIV, 32'h0000_0000);
        chk(q, {24'h00_0000, `DIV_RESET});
        $display("test reset done");
    endtask : t_reset
    // 3-line writes with both flag values
    task automatic t_write3;
        for (int f = 0; f < 2; f++) begin
            frame({30'h0, f[0], 1'b0}, {f[0] ? 8'h3C : 8'hA5, 24'h00_0000});
            chk(n_bits, 9);
            chk(cap[0][8:0], {f[0], f[0] ? 8'h3C : 8'hA5});
        end
        $display("test 3-line write done");
    endtask : t_write3
    // 4-line writes with command pin low and high
    task automatic t_write4;
        for (int f = 0; f < 2; f++) begin
            frame({22'h0, 2'b01, 6'h0, f[0], 1'b0}, 32'h9600_0000);
            chk(interface_select_pins, 4'b1101);
            chk(n_bits, 8);
            chk(cap[0][7:0], 8'h96);
            chk(flag_seen, f[0]);
        end
        $display("test 4-line write done");
    endtask : t_write4
    // Reads of every length in both single-line modes
    task automatic t_read;
        int w;
        for (int m = 0; m < 2; m++) begin
            for (int l = 0; l < 3; l++) begin
                w = (l == 0) ? 8 : (l == 1) ? 24 : 32;
                frame({15'h0, 1'b1, 2'b00, 2'(l), 2'b00, 2'(m), 8'h08}, 32'h0400_0000);
                apb(1'b0, `REG_RXDATA, 32'h0000_0000);
                chk(q, reply >> (32 - w));
                chk(n_bits, (m == 1 ? 8 : 9) + w);
            end
        end
        $display("test read done");
    endtask : t_read
    // Dual-lane pixel write, lanes exchanged by the swap setting
    task automatic t_dual;
        logic [63:0] a0, a1, mk, e0, e1;
        logic [31:0] tx;
        tx = 32'h00C3_5A96;
        e0 = 64'h0;
        e1 = 64'h0;
        // Unswapped: primary line carries D23, D21 .. D1, second line D22 .. D0
        for (int k = 0; k < 12; k++) begin
            e0 = {e0[62:0], tx[23 - 2 * k]};
            e1 = {e1[62:0], tx[22 - 2 * k]};
        end
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 2; s++) begin
                frame({22'h0, 2'(m), 2'b00, s[0], 5'b10010}, tx);
                chk(interface_select_pins, m == 1 ? 4'b1011 : 4'b0110);
                chk(n_bits, 13);
                chk(cap[0][12], 1'b1);
                mk = (64'h1 << (n_bits - 1)) - 64'h1;
                if (s == 1) begin
                    chk(cap[0] & mk, a1 & mk);
                    chk(cap[1] & mk, a0 & mk);
                end else begin
                    chk(cap[0] & mk, e0);
                    chk(cap[1] & mk, e1);
                end
                a0 = cap[0];
                a1 = cap[1];
            end
        end
        $display("test dual done");
    endtask : t_dual
    // Quad writes with each first-byte code, four bits per clock
    task automatic t_quad;
        logic [31:0] g;
        for (int c = 0; c < 3; c++) begin
            frame(32'h0000_0040, {codes[c], 24'hA5_5AC3});
            chk(interface_select_pins, 4'b0101);
            chk(n_bits, 8);
            for (int k = 0; k < 8; k++) begin
                g = {g[27:0], cap[3][7-k], cap[2][7-k], cap[1][7-k], cap[0][7-k]};
            end
            chk(g, {codes[c], 24'hA5_5AC3});
        end
        $display("test quad done");
    endtask : t_quad
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        reply   = 32'hC3A5_5A96;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_reset;
        t_write3;
        t_write4;
        t_read;
        t_dual;
        t_quad;
        results;
    end
    // Watchdog
    initial begin
        #500_000;
        err_total++;
        results;
    end
endmodule : dsp_host_tb
